// *** design/ecs_pkg.sv ***
// constants shared by the ethernet control/status register bank
package ecs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_TX_POLL = 8'h08;
  localparam logic [7:0] OFS_RX_POLL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_NAR = 8'h30;
  localparam logic [7:0] OFS_IER = 8'h38;
  localparam logic [7:0] OFS_MISSED = 8'h40;
  localparam logic [7:0] OFS_SERIAL = 8'h48;
  localparam logic [7:0] OFS_TIMER = 8'h58;
  localparam logic [7:0] OFS_WAKE = 8'h68;
  // ==========================================================
  // status bits
  localparam int ST_TX_DONE = 0;
  localparam int ST_TX_STOP = 1;
  localparam int ST_TX_NODESC = 2;
  localparam int ST_JABBER = 3;
  localparam int ST_UNDERFLOW = 5;
  localparam int ST_RX_DONE = 6;
  localparam int ST_RX_NODESC = 7;
  localparam int ST_RX_STOP = 8;
  localparam int ST_RX_WDOG = 9;
  localparam int ST_TIMER = 11;
  localparam int ST_ABN_SUM = 15;
  localparam int ST_NRM_SUM = 16;
  localparam logic [14:0] NORMAL_MASK = 15'h0045;
  localparam logic [14:0] ABNORMAL_MASK = 15'h0BAA;
  // ==========================================================
  // network access control fields
  localparam int NAR_SF = 21;
  localparam int NAR_TR = 14;
  localparam int NAR_ST = 13;
  localparam int NAR_OM = 10;
  localparam int NAR_MM = 7;
  localparam int NAR_PR = 6;
  localparam int NAR_PB = 3;
  localparam int NAR_SR = 1;
  localparam logic [31:0] NAR_WMASK = 32'h0028FCEA;
  localparam logic [31:0] NAR_RESET = 32'h00080040;
  localparam logic [31:0] IER_WMASK = 32'h0001ABEF;
  // ==========================================================
  // serial port, timer and wake fields
  localparam int SP_MDC = 16;
  localparam int SP_MDO = 17;
  localparam int SP_MMC = 18;
  localparam int SP_MDI = 19;
  localparam int SP_EE_RD = 14;
  localparam int SP_EE_WR = 13;
  localparam int SP_EE_SEL = 11;
  localparam int SP_EE_DO = 3;
  localparam int SP_EE_DI = 2;
  localparam int SP_EE_SK = 1;
  localparam int SP_EE_CS = 0;
  localparam logic [31:0] SPR_WMASK = 32'h00076807;
  localparam logic [31:0] SPR_RESET = 32'h00040007;
  localparam int TMR_COM = 16;
  localparam int WK_PATTERN_CRC_SEED_SELECT = 30;
  localparam int WK_PAT = 25;
  localparam int WK_LOFF = 17;
  localparam int WK_LON = 16;
  localparam int WK_EVT = 8;
  localparam logic [31:0] WAKE_WMASK = 32'h7E030700;
  localparam logic [15:0] CRC_SEED_ONE = 16'hFFFF;
  localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;
  // ==========================================================
  // transmit start thresholds in bytes
  localparam logic [10:0] THR_SF = 11'h7FF;
  localparam logic [43:0] THR_100 = {11'h400, 11'h200, 11'h100, 11'h080};
  localparam logic [43:0] THR_10 = {11'h0A0, 11'h080, 11'h060, 11'h048};
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 204;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
endpackage

// *** design/ecs_timer_if.sv ***
// carrier between the register bank and its general-purpose timer
`timescale 1ns/1ps
`default_nettype none
interface ecs_timer_if;
  logic load;
  logic [16:0] wdata;
  logic [15:0] count;
  logic auto_reload;
  logic expired;
  modport ctrl(output load, output wdata, input count, input auto_reload, input expired);
  modport tmr(input load, input wdata, output count, output auto_reload, output expired);
endinterface
`default_nettype wire

// *** design/ecs_gp_timer.sv ***
// general-purpose countdown timer with its tick divider
`timescale 1ns/1ps
`default_nettype none
module ecs_gp_timer #(
  parameter int TICK_CYCLES = ecs_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  ecs_timer_if.tmr tif
);
  import ecs_pkg::*;
  localparam int DW = $clog2(TICK_CYCLES + 1);
  logic [DW-1:0] div_ff;
  logic [15:0] reload_ff;
  logic [15:0] count_ff;
  logic auto_ff;
  logic expired_ff;
  // ==========================================================
  // tick enable and countdown
  wire tick = (div_ff == DW'(TICK_CYCLES - 1));
  wire running = (count_ff != 16'h0000);
  wire last = tick && (count_ff == 16'h0001);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_ff <= '0;
      reload_ff <= 16'h0000;
      count_ff <= 16'h0000;
      auto_ff <= 1'b0;
      expired_ff <= 1'b0;
    end else if (tif.load) begin
      // a write restarts the period so the first step is a full tick
      div_ff <= '0;
      reload_ff <= tif.wdata[15:0];
      count_ff <= tif.wdata[15:0];
      auto_ff <= tif.wdata[TMR_COM];
      expired_ff <= 1'b0;
    end else begin
      div_ff <= tick ? '0 : div_ff + 1'b1;
      expired_ff <= last;
      if (tick && running) begin
        count_ff <= (last && auto_ff) ? reload_ff : count_ff - 16'h0001;
      end
    end
  end
  assign tif.count = count_ff;
  assign tif.auto_reload = auto_ff;
  assign tif.expired = expired_ff;
endmodule
`default_nettype wire

// *** design/ecs_regs.sv ***
// control and status register bank of the fast ethernet controller
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// What this block does
// - no rx descriptor: flag, suspend, resume
// - tx underflow: flag, suspend, mark descriptor
// - jabber expiry: flag, stop tx, mark descriptor
// - no tx descriptor: flag, suspend until poll
// - tx done flagged only when completion requested
// - process stop events set stop flags
// - status flags sticky, cleared by writing one
// - store and forward ignores threshold
// - threshold code selects tx start bytes
// - run bit starts or stops transmit
// - mode field selects normal or loopback
// - multicast and promiscuous address filter
// - bad frames kept only when enabled
// - rx stop waits for current frame
// - each enable gated by its group enable
// - missed frame counter, overflow, clear on read
// - management pins driven by register bits
// - eeprom pins gated by select and direction
// - timer counts down per tick, optional reload
// - crc seed and pattern enables from wake
// - link edges set link change flag
// - enabled wake events raise event status
// - timer expiry sets timer flag
// - summary flags cover normal and abnormal bits
module ecs_regs #(
  parameter int TICK_CYCLES = ecs_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic tx_done_evt,
  input wire logic tx_ioc,
  input wire logic tx_stop_evt,
  input wire logic tx_nodesc_evt,
  input wire logic tx_jabber_evt,
  input wire logic tx_underflow_evt,
  input wire logic tx_auto_poll_tick,
  input wire logic rx_done_evt,
  input wire logic rx_stop_evt,
  input wire logic rx_nodesc_evt,
  input wire logic rx_wdog_evt,
  input wire logic rx_new_frame_evt,
  input wire logic rx_frame_busy,
  input wire logic missed_frame_evt,
  input wire logic frame_valid,
  input wire logic frame_da_match,
  input wire logic frame_mcast,
  input wire logic frame_bad,
  input wire logic frame_pause_wake,
  input wire logic speed_100,
  input wire logic link_up_pin,
  input wire logic wake_frame_evt,
  input wire logic magic_frame_evt,
  input wire logic mdio_in,
  input wire logic ee_do_pin,
  output logic mdc_o,
  output logic mdio_out,
  output logic mdio_oe_b,
  output logic ee_cs_o,
  output logic ee_sk_o,
  output logic ee_di_o,
  output logic tx_active,
  output logic tx_desc0_underflow,
  output logic tx_desc0_jabber,
  output logic rx_active,
  output logic frame_accept,
  output logic store_forward,
  output logic [10:0] tx_start_bytes,
  output logic [1:0] loopback_select,
  output logic [15:0] pattern_crc_seed,
  output logic [4:0] pattern_match_enable,
  output logic pme_event_status,
  output logic irq_o
);
  import ecs_pkg::*;
  logic [14:0] status_ff;
  logic [31:0] nar_ff;
  logic [31:0] ier_ff;
  logic [31:0] spr_ff;
  logic [31:0] wake_ff;
  logic [2:0] wake_flag_ff;
  logic [15:0] missed_ff;
  logic missed_ovf_ff;
  logic tx_susp_ff;
  logic tx_halt_ff;
  logic rx_susp_ff;
  logic rx_run_ff;
  logic desc_uf_ff;
  logic desc_jab_ff;
  logic accept_ff;
  logic [5:0] pins_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic link_prev_ff;
  logic [31:0] rdata_ff;
  // ==========================================================
  // address decode
  wire wr_status = reg_wr_en && (reg_addr == OFS_STATUS);
  wire wr_nar = reg_wr_en && (reg_addr == OFS_NAR);
  wire wr_ier = reg_wr_en && (reg_addr == OFS_IER);
  wire wr_spr = reg_wr_en && (reg_addr == OFS_SERIAL);
  wire wr_tmr = reg_wr_en && (reg_addr == OFS_TIMER);
  wire wr_wake = reg_wr_en && (reg_addr == OFS_WAKE);
  wire wr_txpoll = reg_wr_en && (reg_addr == OFS_TX_POLL);
  wire wr_rxpoll = reg_wr_en && (reg_addr == OFS_RX_POLL);
  wire rd_missed = reg_rd_en && (reg_addr == OFS_MISSED);
  // ==========================================================
  // pin synchronisers: link, eeprom data, management data
  wire link_s = sync2_ff[2];
  wire ee_do_s = sync2_ff[1];
  wire mdi_s = sync2_ff[0];
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      link_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {link_up_pin, ee_do_pin, mdio_in};
      sync2_ff <= sync1_ff;
      link_prev_ff <= link_s;
    end
  end

  // ==========================================================
  // general-purpose timer
  ecs_timer_if tif();
  ecs_gp_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tif(tif.tmr)
  );
  assign tif.load = wr_tmr;
  assign tif.wdata = reg_wdata[16:0];
  // ==========================================================
  // status flags
  logic [14:0] flag_set;
  always_comb begin
    flag_set = 15'h0000;
    flag_set[ST_TX_DONE] = tx_done_evt && tx_ioc;
    flag_set[ST_TX_STOP] = tx_stop_evt;
    flag_set[ST_TX_NODESC] = tx_nodesc_evt;
    flag_set[ST_JABBER] = tx_jabber_evt;
    flag_set[ST_UNDERFLOW] = tx_underflow_evt;
    flag_set[ST_RX_DONE] = rx_done_evt;
    flag_set[ST_RX_NODESC] = rx_nodesc_evt;
    flag_set[ST_RX_STOP] = rx_stop_evt;
    flag_set[ST_RX_WDOG] = rx_wdog_evt;
    flag_set[ST_TIMER] = tif.expired;
  end
  wire [14:0] clr_mask = wr_status ? reg_wdata[14:0] : 15'h0000;
  wire [14:0] keep_mask = status_ff & ~clr_mask;
  // a new event in the clearing cycle still lands
  wire [14:0] nxt_status = keep_mask | flag_set;
  wire nrm_sum = |(status_ff & NORMAL_MASK);
  wire abn_sum = |(status_ff & ABNORMAL_MASK);
  wire [14:0] live = status_ff & ier_ff[14:0];
  wire nrm_irq = ier_ff[ST_NRM_SUM] && |(live & NORMAL_MASK);
  wire abn_irq = ier_ff[ST_ABN_SUM] && |(live & ABNORMAL_MASK);
  assign irq_o = nrm_irq || abn_irq;
  // ==========================================================
  // process suspension and halt
  wire nxt_tx_susp = tx_nodesc_evt || tx_underflow_evt ||
                     (tx_susp_ff && !wr_txpoll && !tx_auto_poll_tick);
  wire nxt_rx_susp = rx_nodesc_evt ||
                     (rx_susp_ff && !wr_rxpoll && !rx_new_frame_evt);
  wire nxt_tx_halt = tx_jabber_evt || (tx_halt_ff && !wr_nar);
  wire rx_run_en = nar_ff[NAR_SR];
  // receive drains the frame in flight before it stops
  wire nxt_rx_run = rx_run_en || (rx_run_ff && rx_frame_busy);
  assign tx_active = nar_ff[NAR_ST] && !tx_halt_ff && !tx_susp_ff;
  assign rx_active = rx_run_ff && !rx_susp_ff;
  assign tx_desc0_underflow = desc_uf_ff;
  assign tx_desc0_jabber = desc_jab_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      status_ff <= 15'h0000;
      tx_susp_ff <= 1'b0;
      rx_susp_ff <= 1'b0;
      tx_halt_ff <= 1'b0;
      rx_run_ff <= 1'b0;
      desc_uf_ff <= 1'b0;
      desc_jab_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      tx_susp_ff <= nxt_tx_susp;
      rx_susp_ff <= nxt_rx_susp;
      tx_halt_ff <= nxt_tx_halt;
      rx_run_ff <= nxt_rx_run;
      desc_uf_ff <= tx_underflow_evt;
      desc_jab_ff <= tx_jabber_evt;
    end
  end

  // ==========================================================
  // network access control and filtering
  // restricted fields are not guarded: software writes them only while stopped
  assign store_forward = nar_ff[NAR_SF];
  assign loopback_select = nar_ff[NAR_OM +: 2];
  wire [1:0] thr_code = nar_ff[NAR_TR +: 2];
  wire [43:0] thr_tab = speed_100 ? THR_100 : THR_10;
  wire [10:0] thr_bytes = thr_tab[11 * thr_code +: 11];
  assign tx_start_bytes = store_forward ? THR_SF : thr_bytes;
  wire addr_ok = nar_ff[NAR_PR] || frame_da_match ||
                 (frame_mcast && nar_ff[NAR_MM]);
  wire bad_ok = !frame_bad || nar_ff[NAR_PB];
  // pause and wake frames pass even while normal reception is stopped
  wire rx_open = rx_active || frame_pause_wake;
  wire nxt_accept = frame_valid && rx_open && addr_ok && bad_ok;
  // ==========================================================
  // missed frame counter
  wire cnt_full = (missed_ff == 16'hFFFF);
  logic [15:0] nxt_missed;
  logic nxt_ovf;
  always_comb begin
    nxt_missed = missed_ff;
    nxt_ovf = missed_ovf_ff;
    if (rd_missed) begin
      nxt_missed = missed_frame_evt ? 16'h0001 : 16'h0000;
      nxt_ovf = 1'b0;
    end else if (missed_frame_evt) begin
      nxt_missed = missed_ff + 16'h0001;
      nxt_ovf = missed_ovf_ff || cnt_full;
    end
  end

  // ==========================================================
  // serial port pins
  wire ee_access = spr_ff[SP_EE_SEL] && (spr_ff[SP_EE_RD] || spr_ff[SP_EE_WR]);
  wire [5:0] nxt_pins = {spr_ff[SP_MDC], spr_ff[SP_MDO], spr_ff[SP_MMC],
                         ee_access && spr_ff[SP_EE_CS], ee_access && spr_ff[SP_EE_SK],
                         ee_access && spr_ff[SP_EE_DI]};
  assign mdc_o = pins_ff[5];
  assign mdio_out = pins_ff[4];
  // read direction releases the data pin
  assign mdio_oe_b = pins_ff[3];
  assign ee_cs_o = pins_ff[2];
  assign ee_sk_o = pins_ff[1];
  assign ee_di_o = pins_ff[0];
  // ==========================================================
  // wake control
  wire link_on = link_s && !link_prev_ff;
  wire link_off = !link_s && link_prev_ff;
  wire lsc_set = (link_off && wake_ff[WK_LOFF]) || (link_on && wake_ff[WK_LON]);
  wire [2:0] wake_set = {wake_frame_evt, magic_frame_evt, lsc_set};
  wire [2:0] wake_clr = wr_wake ? reg_wdata[2:0] : 3'h0;
  wire [2:0] nxt_wake_flag = (wake_flag_ff & ~wake_clr) | wake_set;
  assign pme_event_status = |(wake_flag_ff & wake_ff[WK_EVT +: 3]);
  assign pattern_crc_seed = wake_ff[WK_PATTERN_CRC_SEED_SELECT] ? CRC_SEED_ONE : CRC_SEED_ZERO;
  assign pattern_match_enable = wake_ff[WK_PAT +: 5];
  // ==========================================================
  // control registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      nar_ff <= NAR_RESET;
      ier_ff <= 32'h00000000;
      spr_ff <= SPR_RESET;
      wake_ff <= 32'h00000000;
      wake_flag_ff <= 3'h0;
      missed_ff <= 16'h0000;
      missed_ovf_ff <= 1'b0;
      pins_ff <= 6'h08;
      accept_ff <= 1'b0;
    end else begin
      if (wr_nar) begin
        nar_ff <= reg_wdata & NAR_WMASK;
      end
      if (wr_ier) begin
        ier_ff <= reg_wdata & IER_WMASK;
      end
      if (wr_spr) begin
        spr_ff <= reg_wdata & SPR_WMASK;
      end
      if (wr_wake) begin
        wake_ff <= reg_wdata & WAKE_WMASK;
      end
      wake_flag_ff <= nxt_wake_flag;
      missed_ff <= nxt_missed;
      missed_ovf_ff <= nxt_ovf;
      pins_ff <= nxt_pins;
      accept_ff <= nxt_accept;
    end
  end
  assign frame_accept = accept_ff;
  // ==========================================================
  // read data
  wire [31:0] rd_status = {15'h0000, nrm_sum, abn_sum, status_ff};
  wire [31:0] rd_spr = {12'h000, mdi_s, spr_ff[18:4], ee_do_s, spr_ff[2:0]};
  wire [31:0] rd_tmr = {15'h0000, tif.auto_reload, tif.count};
  wire [31:0] rd_wake = {wake_ff[31:3], wake_flag_ff};
  wire [31:0] rd_missed_w = {15'h0000, missed_ovf_ff, missed_ff};
  wire [31:0] nxt_rdata =
    (reg_addr == OFS_STATUS) ? rd_status :
    (reg_addr == OFS_NAR) ? nar_ff :
    (reg_addr == OFS_IER) ? ier_ff :
    (reg_addr == OFS_MISSED) ? rd_missed_w :
    (reg_addr == OFS_SERIAL) ? rd_spr :
    (reg_addr == OFS_TIMER) ? rd_tmr :
    (reg_addr == OFS_WAKE) ? rd_wake : 32'h00000000;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;
  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_rx_starved;
    rx_nodesc_evt ##1 (status_ff[ST_RX_NODESC] && rx_susp_ff);
  endsequence
  sequence s_rx_resumed;
    (wr_rxpoll || rx_new_frame_evt) && !rx_nodesc_evt ##1 !rx_susp_ff;
  endsequence

  a_rx_nodesc_suspend: assert property (rx_nodesc_evt |-> s_rx_starved)
    else $error("rx starvation not flagged");
  a_rx_resume_path: assert property (rx_susp_ff && (wr_rxpoll || rx_new_frame_evt) && !rx_nodesc_evt
    |-> s_rx_resumed)
    else $error("rx did not resume");
  a_tx_underflow_susp: assert property (tx_underflow_evt |=> status_ff[ST_UNDERFLOW] && tx_susp_ff
    && tx_desc0_underflow)
    else $error("underflow handling wrong");
  a_jabber_halts_tx: assert property (tx_jabber_evt && !wr_nar |=> !tx_active
    && status_ff[ST_JABBER] && tx_desc0_jabber)
    else $error("jabber did not stop tx");
  a_tx_nodesc_hold: assert property (tx_susp_ff && !wr_txpoll && !tx_auto_poll_tick
    |=> tx_susp_ff)
    else $error("tx left suspension without poll");
  a_tx_done_ioc: assert property (tx_done_evt && !tx_ioc && !status_ff[ST_TX_DONE]
    |=> !status_ff[ST_TX_DONE])
    else $error("tx done flagged without request");
  a_stop_flags_set: assert property (rx_stop_evt && tx_stop_evt
    |=> status_ff[ST_RX_STOP] && status_ff[ST_TX_STOP])
    else $error("stop flags missing");
  a_flag_sticky_hold: assert property (!wr_status |=> (status_ff & $past(status_ff)) == $past(status_ff))
    else $error("flag dropped without clear");
  a_sf_threshold_max: assert property (store_forward |-> tx_start_bytes == THR_SF)
    else $error("threshold used in store and forward");
  a_rx_stop_drain: assert property (rx_run_ff && rx_frame_busy |=> rx_run_ff)
    else $error("rx stopped mid frame");
  a_irq_group_gate: assert property (!ier_ff[ST_NRM_SUM] && !ier_ff[ST_ABN_SUM] |-> !irq_o)
    else $error("irq without group enable");
  a_missed_read_clear: assert property (rd_missed && !missed_frame_evt
    |=> missed_ff == 16'h0000 && !missed_ovf_ff)
    else $error("missed counter not cleared");
  a_ee_pins_gated: assert property (!spr_ff[SP_EE_SEL] |=> !ee_cs_o && !ee_sk_o)
    else $error("eeprom pins active without select");
  a_mdio_direction: assert property (spr_ff[SP_MMC] |=> mdio_oe_b)
    else $error("mdio driven during read");
endmodule
`default_nettype wire

// *** bench/ecs_regs_tb.sv ***
// self-checking testbench for the ethernet control/status register bank
`timescale 1ns/1ps
`default_nettype none
module ecs_regs_tb;
  import ecs_pkg::*;
  // ==========================================================
  // design signals, names match the ports for the wildcard hookup
  logic core_clk, rst_b, reg_wr_en, reg_rd_en, tx_ioc, rx_frame_busy, frame_da_match, frame_mcast, frame_bad;
  logic frame_pause_wake, speed_100, link_up_pin, mdio_in, ee_do_pin;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [14:0] ev;
  wire tx_done_evt, tx_stop_evt, tx_nodesc_evt, tx_jabber_evt, tx_underflow_evt, tx_auto_poll_tick, rx_done_evt;
  wire rx_stop_evt, rx_nodesc_evt, rx_wdog_evt, rx_new_frame_evt, missed_frame_evt, frame_valid;
  wire wake_frame_evt, magic_frame_evt;
  logic mdc_o, mdio_out, mdio_oe_b, ee_cs_o, ee_sk_o, ee_di_o, tx_active, tx_desc0_underflow, tx_desc0_jabber;
  logic rx_active, frame_accept, store_forward, pme_event_status, irq_o;
  logic [10:0] tx_start_bytes;
  logic [1:0] loopback_select;
  logic [15:0] pattern_crc_seed;
  logic [4:0] pattern_match_enable;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  // event pulses are packed so that bit n lands on status bit n for bits 0 to 9 where one exists; bit 11 is rx_new_frame_evt, not the timer flag
  assign {magic_frame_evt, wake_frame_evt, frame_valid, rx_new_frame_evt, tx_auto_poll_tick, rx_wdog_evt,
    rx_stop_evt, rx_nodesc_evt, rx_done_evt, tx_underflow_evt, missed_frame_evt, tx_jabber_evt,
    tx_nodesc_evt, tx_stop_evt, tx_done_evt} = ev;
  // short tick so the timer expires within a few dozen cycles
  ecs_regs #(.TICK_CYCLES(4)) u_ecs_regs (.*);
  always #10 core_clk = ~core_clk;
  // ==========================================================
  // shared tasks
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk) reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk) reg_wr_en = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk) reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge core_clk) reg_rd_en = 1'b0;
    v = reg_rdata;
  endtask
  task automatic pulse(input logic [14:0] m);
    @(negedge core_clk) ev = m;
    @(negedge core_clk) ev = '0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_status;
    for (int b = 0; b < 10; b++) begin
      if (b != 4) begin
        pulse(15'(1 << b));
        if (b == 5) chk(tx_desc0_underflow, 1);
        if (b == 3) chk(tx_desc0_jabber, 1);
        rd(OFS_STATUS);
        chk(v, (32'h1 << b) | ((b == 0 || b == 2 || b == 6) ? 32'h10000 : 32'h8000));
        rd(OFS_STATUS);
        chk(v[b], 1);
        wr(OFS_STATUS, 32'h1 << b);
        rd(OFS_STATUS);
        chk(v, 0);
      end
    end
    pulse(15'h0102);
    rd(OFS_STATUS);
    chk(v, 32'h0000_8102);
    wr(OFS_STATUS, 32'h0000_0102);
    tx_ioc = 1'b0;
    pulse(15'h0001);
    rd(OFS_STATUS);
    chk(v, 0);
    wr(OFS_IER, 32'h20);
    pulse(15'h0020);
    chk(irq_o, 0);
    wr(OFS_IER, 32'h8020);
    chk(irq_o, 1);
    wr(OFS_STATUS, 32'h20);
    chk(irq_o, 0);
  endtask
  task automatic t_counter;
    repeat (3) pulse(15'h0010);
    rd(OFS_MISSED);
    chk(v, 3);
    rd(OFS_MISSED);
    chk(v, 0);
  endtask
  task automatic acc(input logic [31:0] f, input logic e);
    // filter fields change only while the receiver is stopped
    wr(OFS_NAR, f);
    wr(OFS_NAR, f | 32'h2);
    pulse(15'h1000);
    chk(frame_accept, e);
    wr(OFS_NAR, f);
  endtask
  task automatic t_nar;
    logic [10:0] thr [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_NAR, 32'(i) << 14);
      chk(tx_start_bytes, thr[i]);
    end
    wr(OFS_NAR, 32'h0020_0400);
    chk(store_forward, 1);
    chk(tx_start_bytes, 11'h7FF);
    chk(loopback_select, 2'h1);
    // receiver still suspended from the starvation event earlier
    wr(OFS_NAR, 32'h0000_0002);
    chk(rx_active, 0);
    wr(OFS_RX_POLL, 32'h0000_0000);
    chk(rx_active, 1);
    rx_frame_busy = 1'b1;
    wr(OFS_NAR, 32'h0000_0000);
    chk(rx_active, 1);
    rx_frame_busy = 1'b0;
    @(negedge core_clk);
    chk(rx_active, 0);
    acc(32'h40, 1'b1);
    frame_bad = 1'b1;
    acc(32'h40, 1'b0);
    acc(32'h48, 1'b1);
    frame_bad = 1'b0;
    frame_mcast = 1'b1;
    acc(32'h0, 1'b0);
    acc(32'h80, 1'b1);
    frame_pause_wake = 1'b1;
    pulse(15'h1000);
    chk(frame_accept, 1);
    frame_pause_wake = 1'b0;
    // transmitter still suspended from the underflow event earlier
    wr(OFS_NAR, 32'h0000_2000);
    chk(tx_active, 0);
    wr(OFS_TX_POLL, 32'h0000_0000);
    chk(tx_active, 1);
    wr(OFS_NAR, 32'h0000_0000);
    chk(tx_active, 0);
  endtask
  task automatic t_misc;
    wr(OFS_TIMER, 32'h2);
    repeat (3) @(negedge core_clk);
    rd(OFS_TIMER);
    chk(v, 1);
    repeat (20) @(negedge core_clk);
    rd(OFS_STATUS);
    chk(v, 32'h8800);
    rd(OFS_TIMER);
    chk(v, 0);
    wr(OFS_SERIAL, 32'h0003_0000);
    chk({mdc_o, mdio_out, mdio_oe_b}, 3'b110);
    wr(OFS_SERIAL, 32'h0000_4807);
    chk({ee_cs_o, ee_sk_o, ee_di_o}, 3'b111);
    mdio_in = 1'b1;
    ee_do_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    rd(OFS_SERIAL);
    chk(v[19], 1);
    chk(v[3], 1);
    wr(OFS_WAKE, 32'h4201_0100);
    chk(pattern_crc_seed, 16'hFFFF);
    chk(pattern_match_enable, 5'h01);
    link_up_pin = 1'b1;
    repeat (6) @(negedge core_clk);
    rd(OFS_WAKE);
    chk(v[0], 1);
    chk(pme_event_status, 1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {reg_wr_en, reg_rd_en, rx_frame_busy, frame_da_match, frame_mcast, frame_bad, frame_pause_wake} = '0;
    {link_up_pin, mdio_in, ee_do_pin, reg_addr, reg_wdata, ev} = '0;
    tx_ioc = 1'b1;
    speed_100 = 1'b1;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    rd(OFS_NAR);
    chk(v, 32'h0008_0040);
    rd(OFS_SERIAL);
    chk(v, 32'h0004_0007);
    chk(mdio_oe_b, 1);
    t_status;
    t_counter;
    t_nar;
    t_misc;
    test_done;
  end
endmodule
`default_nettype wire
